// file: scc_partner.sv
// behavioural spi slave facing the block in master mode
`timescale 1ns/10ps
module scc_partner (
  // serial link
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // format and data
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sh;
  logic first;
  wire lead = sclk_i ^ clock_polarity_i;
  task automatic put();
    if (!first) sh = lsb_i ? sh >> 1 : sh << 1;
    first = 1'b0;
    miso_o = lsb_i ? sh[0] : sh[7];
  endtask
  task automatic get();
    rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
  endtask
  initial begin
    miso_o = 1'b0;
    rx_o = 8'h00;
  end
  // released line flips, never stale
  always @(posedge ss_n_i) miso_o = ~miso_o;
  always @(negedge ss_n_i) begin
    sh = tx_i;
    first = 1'b1;
    if (!clock_phase_i) put();
  end
  always @(posedge lead) begin
    if (!ss_n_i && clock_phase_i) put();
    if (!ss_n_i && !clock_phase_i) get();
  end
  always @(negedge lead) begin
    if (!ss_n_i && !clock_phase_i) put();
    if (!ss_n_i && clock_phase_i) get();
  end
endmodule

// file: scc_pkg.sv
// constants and types shared by the spi control block
package scc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADR_CTRL_MAIN = 5'h00;
  localparam logic [4:0] ADR_CTRL_OPTIONS = 5'h04;
  localparam logic [4:0] ADR_STATUS = 5'h08;
  localparam logic [4:0] ADR_DATA = 5'h0c;

  // ----------------------------------------------------------------
  // spi_control_main fields
  // ----------------------------------------------------------------
  localparam int MAIN_RX_FAULT_IRQ_EN = 7;
  localparam int MAIN_SYS_ENABLE = 6;
  localparam int MAIN_TX_EMPTY_IRQ_EN = 5;
  localparam int MAIN_MASTER_SELECT = 4;
  localparam int MAIN_CLOCK_POLARITY = 3;
  localparam int MAIN_CLOCK_PHASE = 2;
  localparam int MAIN_SELECT_OUT_EN = 1;
  localparam int MAIN_LOW_BIT_FIRST = 0;
  localparam logic [7:0] MAIN_RESET = 8'h00;

  // ----------------------------------------------------------------
  // spi_control_options fields
  // ----------------------------------------------------------------
  localparam int OPT_FAULT_DETECT_EN = 4;
  localparam int OPT_SINGLE_WIRE_OUT_EN = 3;
  localparam int OPT_WAIT_CLOCK_STOP = 1;
  localparam int OPT_SINGLE_WIRE_SELECT = 0;
  localparam logic [7:0] OPT_IMPL_MASK = 8'h1b;
  localparam logic [7:0] OPT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int STAT_RX_FULL = 7;
  localparam int STAT_TX_EMPTY = 5;
  localparam int STAT_FAULT = 4;

  // ----------------------------------------------------------------
  // pin indices
  // ----------------------------------------------------------------
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS = 3;
  localparam int PIN_COUNT = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS = 400;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_RUN = 2'b01,
    SCC_FIN = 2'b10
  } scc_state_t;

endpackage

// file: scc_shift_if.sv
// signals between the control block and its shift engine
`timescale 1ns/10ps
interface scc_shift_if;
  logic enable;
  logic halt;
  logic master;
  logic clock_polarity;
  logic clock_phase;
  logic lsb_first;
  logic load;
  logic [7:0] load_data;
  logic sclk_in;
  logic selected;
  logic din;
  logic ready;
  logic busy;
  logic sclk_out;
  logic dout;
  logic done;
  logic [7:0] rx_data;

  modport ctrl (
    output enable, halt, master, clock_polarity, clock_phase, lsb_first, load, load_data, sclk_in, selected, din,
    input ready, busy, sclk_out, dout, done, rx_data
  );
  modport eng (
    input enable, halt, master, clock_polarity, clock_phase, lsb_first, load, load_data, sclk_in, selected, din,
    output ready, busy, sclk_out, dout, done, rx_data
  );
endinterface

// file: scc_shifter.sv
// byte shift engine for master and slave transfers
`timescale 1ns/10ps
module scc_shifter (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // control side
  scc_shift_if.eng sh
);

  scc_pkg::scc_state_t state;
  logic [7:0] tx;
  logic [7:0] rx;
  logic have;
  logic [3:0] timer;
  logic [4:0] ecnt;
  logic [2:0] bidx;
  logic [2:0] ridx;
  logic toggle;
  logic sclk_prev;
  logic edge_ev;
  logic [4:0] k;
  logic sample;
  logic advance;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sh.sclk_in;
    end
  end

  always_comb begin
    if (sh.master) begin
      edge_ev = (state == scc_pkg::SCC_RUN) && (timer == scc_pkg::SCK_HALF_LAST);
    end else begin
      edge_ev = (state == scc_pkg::SCC_RUN) && (sh.sclk_in != sclk_prev);
    end
    edge_ev = edge_ev && !sh.halt;
    k = ecnt + 5'h01;
    sample = k[0] ^ sh.clock_phase;
    advance = !sample && !(sh.clock_phase && k == 5'h01) && (k != scc_pkg::EDGES_PER_BYTE);
  end

  assign sh.ready = (state == scc_pkg::SCC_IDLE) && !have && !(!sh.master && sh.selected);
  assign sh.busy = (state != scc_pkg::SCC_IDLE);
  assign sh.sclk_out = sh.clock_polarity ^ toggle;
  assign sh.dout = sh.lsb_first ? tx[bidx] : tx[3'h7 - bidx];

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= scc_pkg::SCC_IDLE;
      have <= 1'b0;
      tx <= 8'h00;
      rx <= 8'h00;
      timer <= 4'h0;
      ecnt <= 5'h00;
      bidx <= 3'h0;
      ridx <= 3'h0;
      toggle <= 1'b0;
      sh.done <= 1'b0;
      sh.rx_data <= 8'h00;
    end else if (!sh.enable) begin
      state <= scc_pkg::SCC_IDLE;
      have <= 1'b0;
      toggle <= 1'b0;
      sh.done <= 1'b0;
    end else begin
      sh.done <= 1'b0;
      unique case (state)
        scc_pkg::SCC_IDLE: begin
          timer <= 4'h0;
          ecnt <= 5'h00;
          bidx <= 3'h0;
          ridx <= 3'h0;
          toggle <= 1'b0;
          if (sh.load) begin
            tx <= sh.load_data;
            have <= 1'b1;
          end
          if (sh.master ? (have || sh.load) : sh.selected) begin
            state <= scc_pkg::SCC_RUN;
            if (!have && !sh.load) begin
              tx <= 8'h00;
            end
          end
        end
        scc_pkg::SCC_RUN: begin
          if (!sh.master && !sh.selected) begin
            state <= scc_pkg::SCC_IDLE;
            have <= 1'b0;
          end else if (!sh.halt) begin
            timer <= (timer == scc_pkg::SCK_HALF_LAST) ? 4'h0 : timer + 4'h1;
            if (edge_ev) begin
              ecnt <= k;
              if (sh.master) begin
                toggle <= ~toggle;
              end
              if (sample) begin
                if (sh.lsb_first) begin
                  rx[ridx] <= sh.din;
                end else begin
                  rx[3'h7 - ridx] <= sh.din;
                end
                ridx <= ridx + 3'h1;
              end
              if (advance) begin
                bidx <= bidx + 3'h1;
              end
              if (k == scc_pkg::EDGES_PER_BYTE) begin
                state <= scc_pkg::SCC_FIN;
              end
            end
          end
        end
        scc_pkg::SCC_FIN: begin
          sh.done <= 1'b1;
          sh.rx_data <= rx;
          have <= 1'b0;
          toggle <= 1'b0;
          state <= scc_pkg::SCC_IDLE;
        end
        default: begin
          state <= scc_pkg::SCC_IDLE;
        end
      endcase
    end
  end

endmodule

// file: scc_top.sv
// spi control registers, flags, pin ownership and link muxing
//
// Function
// - rx/fault interrupt enable requests interrupt while rx full or fault flag set.
// - clearing system enable aborts transfers, flushes buffers, resets state machines.
// - disabling clears rx full flag and sets tx empty flag.
// - tx interrupt enable requests interrupt while tx empty flag set.
// - master select picks slave at 0, master at 1.
// - clock polarity inverts serial clock; 1 idles high.
// - clock phase puts first edge mid first bit at 0, start at 1.
// - low bit first sends lsb first at 1, msb first at 0.
// - master without fault detect releases select pin to general purpose.
// - master with fault detect, no select out: select pin is fault input.
// - master with fault detect and select out drives select automatically.
// - slave always uses select pin as active-low input.
// - options bits 7,6,5,2 read zero.
// - single-wire out enable turns shared data driver on or off.
// - single-wire out enable ignored without single-wire mode.
// - wait clock stop halts shifting while processor in wait mode.
// - single-wire select chooses separate pins or one bidirectional pin.
// - single-wire slave carries data on the miso pin.
// - single-wire master carries data on the mosi pin.
// - disabled block releases all four pins to port control.
// - single-wire leaves the other data pin to general purpose.
`timescale 1ns/10ps
module scc_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // processor state
  input wire logic wait_mode_i,
  // serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o,
  // mosi pin
  input wire logic mosi_pin_i,
  output logic mosi_pin_o,
  output logic mosi_pin_oe_n_o,
  // miso pin
  input wire logic miso_pin_i,
  output logic miso_pin_o,
  output logic miso_pin_oe_n_o,
  // slave select pin
  input wire logic ss_pin_i,
  output logic ss_pin_o,
  output logic ss_pin_oe_n_o,
  // pin ownership and interrupt
  output logic [3:0] pin_spi_own_o,
  output logic irq_o
);

  scc_shift_if sh ();

  logic [7:0] spi_control_main;
  logic [7:0] spi_control_options;
  logic [3:0] pin_raw;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic rx_full_flag;
  logic tx_empty_flag;
  logic fault_flag;
  logic seen_rx;
  logic seen_tx;
  logic seen_fault;
  logic tx_full;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic [7:0] rd_mux;
  logic bus_req;
  logic bus_done;
  logic wr_done;
  logic rd_done;
  logic data_wr_ok;
  logic fault_evt;
  logic sys_enable;
  logic master_select;
  logic fault_detect_en;
  logic select_out_en;
  logic single_wire_select;
  logic single_wire_out_en;
  logic bidir_drive;
  logic [3:0] next_own;
  logic [3:0] next_oe_n;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign sys_enable = spi_control_main[scc_pkg::MAIN_SYS_ENABLE];
  assign master_select = spi_control_main[scc_pkg::MAIN_MASTER_SELECT];
  assign select_out_en = spi_control_main[scc_pkg::MAIN_SELECT_OUT_EN];
  assign fault_detect_en = spi_control_options[scc_pkg::OPT_FAULT_DETECT_EN];
  assign single_wire_select = spi_control_options[scc_pkg::OPT_SINGLE_WIRE_SELECT];
  assign single_wire_out_en = spi_control_options[scc_pkg::OPT_SINGLE_WIRE_OUT_EN];
  // out enable only counts in single-wire mode
  assign bidir_drive = single_wire_select & single_wire_out_en;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {ss_pin_i, miso_pin_i, mosi_pin_i, serial_clock_pin_i};

  genvar g;
  generate
    for (g = 0; g < scc_pkg::PIN_COUNT; g = g + 1) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1[g] <= 1'b1;
          sync2[g] <= 1'b1;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shift engine hookup
  // ----------------------------------------------------------------
  assign sh.enable = sys_enable & !fault_evt;
  assign sh.halt = spi_control_options[scc_pkg::OPT_WAIT_CLOCK_STOP] & wait_mode_i;
  assign sh.master = master_select;
  assign sh.clock_polarity = spi_control_main[scc_pkg::MAIN_CLOCK_POLARITY];
  assign sh.clock_phase = spi_control_main[scc_pkg::MAIN_CLOCK_PHASE];
  assign sh.lsb_first = spi_control_main[scc_pkg::MAIN_LOW_BIT_FIRST];
  assign sh.load = tx_full & sh.ready & sys_enable;
  assign sh.load_data = tx_buf;
  assign sh.sclk_in = sync2[scc_pkg::PIN_SCK];
  assign sh.selected = !sync2[scc_pkg::PIN_SS];

  // data input pin by mode
  always_comb begin
    if (master_select) begin
      sh.din = single_wire_select ? sync2[scc_pkg::PIN_MOSI] : sync2[scc_pkg::PIN_MISO];
    end else begin
      sh.din = single_wire_select ? sync2[scc_pkg::PIN_MISO] : sync2[scc_pkg::PIN_MOSI];
    end
  end

  scc_shifter u_shifter (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .sh(sh)
  );

  // master sees select low while acting as fault input
  assign fault_evt = sys_enable & master_select & fault_detect_en & !select_out_en
                     & !sync2[scc_pkg::PIN_SS];

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i;
  // effects land on the edge where the master sees ack
  assign bus_done = bus_req & wb_ack_o;
  assign wr_done = bus_done & wb_we_i & wb_sel_i[0];
  assign rd_done = bus_done & !wb_we_i;
  assign data_wr_ok = wr_done & (wb_adr_i == scc_pkg::ADR_DATA) & sys_enable & tx_empty_flag & seen_tx;

  always_comb begin
    unique case (wb_adr_i)
      scc_pkg::ADR_CTRL_MAIN: rd_mux = spi_control_main;
      scc_pkg::ADR_CTRL_OPTIONS: rd_mux = spi_control_options & scc_pkg::OPT_IMPL_MASK;
      scc_pkg::ADR_STATUS: rd_mux = {rx_full_flag, 1'b0, tx_empty_flag, fault_flag, 4'h0};
      scc_pkg::ADR_DATA: rd_mux = rx_buf;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & !wb_ack_o;
      if (bus_req & !wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_control_main <= scc_pkg::MAIN_RESET;
      spi_control_options <= scc_pkg::OPT_RESET;
    end else if (wr_done) begin
      if (wb_adr_i == scc_pkg::ADR_CTRL_MAIN) begin
        spi_control_main <= wb_dat_i[7:0];
      end
      if (wb_adr_i == scc_pkg::ADR_CTRL_OPTIONS) begin
        spi_control_options <= wb_dat_i[7:0] & scc_pkg::OPT_IMPL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags and buffers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_full_flag <= 1'b0;
      rx_buf <= 8'h00;
      seen_rx <= 1'b0;
    end else if (!sys_enable) begin
      rx_full_flag <= 1'b0;
      seen_rx <= 1'b0;
    end else if (sh.done) begin
      // a completing byte beats a clearing read
      rx_full_flag <= 1'b1;
      rx_buf <= sh.rx_data;
    end else if (rd_done & (wb_adr_i == scc_pkg::ADR_STATUS) & rx_full_flag) begin
      seen_rx <= 1'b1;
    end else if (rd_done & (wb_adr_i == scc_pkg::ADR_DATA) & seen_rx) begin
      rx_full_flag <= 1'b0;
      seen_rx <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_empty_flag <= 1'b1;
      tx_full <= 1'b0;
      tx_buf <= 8'h00;
      seen_tx <= 1'b0;
    end else if (!sys_enable) begin
      tx_empty_flag <= 1'b1;
      tx_full <= 1'b0;
      seen_tx <= 1'b0;
    end else if (sh.load) begin
      tx_empty_flag <= 1'b1;
      tx_full <= 1'b0;
    end else if (data_wr_ok) begin
      tx_buf <= wb_dat_i[7:0];
      tx_full <= 1'b1;
      tx_empty_flag <= 1'b0;
      seen_tx <= 1'b0;
    end else if (rd_done & (wb_adr_i == scc_pkg::ADR_STATUS) & tx_empty_flag) begin
      seen_tx <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_flag <= 1'b0;
      seen_fault <= 1'b0;
    end else if (fault_evt) begin
      fault_flag <= 1'b1;
    end else if (rd_done & (wb_adr_i == scc_pkg::ADR_STATUS) & fault_flag) begin
      seen_fault <= 1'b1;
    end else if (wr_done & (wb_adr_i == scc_pkg::ADR_CTRL_MAIN) & seen_fault) begin
      fault_flag <= 1'b0;
      seen_fault <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (spi_control_main[scc_pkg::MAIN_RX_FAULT_IRQ_EN] & (rx_full_flag | fault_flag))
               | (spi_control_main[scc_pkg::MAIN_TX_EMPTY_IRQ_EN] & tx_empty_flag);
    end
  end

  // ----------------------------------------------------------------
  // pin ownership and drivers
  // ----------------------------------------------------------------
  always_comb begin
    next_own = 4'h0;
    next_oe_n = 4'hf;
    if (sys_enable) begin
      next_own[scc_pkg::PIN_SCK] = 1'b1;
      next_oe_n[scc_pkg::PIN_SCK] = !master_select;
      if (master_select) begin
        next_own[scc_pkg::PIN_MOSI] = 1'b1;
        next_oe_n[scc_pkg::PIN_MOSI] = single_wire_select ? !bidir_drive : 1'b0;
        next_own[scc_pkg::PIN_MISO] = !single_wire_select;
        next_own[scc_pkg::PIN_SS] = fault_detect_en;
        next_oe_n[scc_pkg::PIN_SS] = !(fault_detect_en & select_out_en);
      end else begin
        next_own[scc_pkg::PIN_MOSI] = !single_wire_select;
        next_own[scc_pkg::PIN_MISO] = 1'b1;
        // slave only drives while selected, to share the line
        next_oe_n[scc_pkg::PIN_MISO] = !(sh.selected & (!single_wire_select | bidir_drive));
        next_own[scc_pkg::PIN_SS] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_spi_own_o <= 4'h0;
      serial_clock_pin_oe_n_o <= 1'b1;
      mosi_pin_oe_n_o <= 1'b1;
      miso_pin_oe_n_o <= 1'b1;
      ss_pin_oe_n_o <= 1'b1;
    end else begin
      pin_spi_own_o <= next_own;
      serial_clock_pin_oe_n_o <= next_oe_n[scc_pkg::PIN_SCK];
      mosi_pin_oe_n_o <= next_oe_n[scc_pkg::PIN_MOSI];
      miso_pin_oe_n_o <= next_oe_n[scc_pkg::PIN_MISO];
      ss_pin_oe_n_o <= next_oe_n[scc_pkg::PIN_SS];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_clock_pin_o <= 1'b0;
      mosi_pin_o <= 1'b0;
      miso_pin_o <= 1'b0;
      ss_pin_o <= 1'b1;
    end else begin
      serial_clock_pin_o <= sh.sclk_out;
      mosi_pin_o <= sh.dout;
      miso_pin_o <= sh.dout;
      ss_pin_o <= !sh.busy;
    end
  end

endmodule

// file: scc_top_checker.sv
// assertions on the spi control block ports
`timescale 1ns/10ps
module scc_top_checker (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic mosi_pin_oe_n_o,
  input wire logic miso_pin_oe_n_o,
  input wire logic ss_pin_oe_n_o,
  input wire logic [3:0] pin_spi_own_o,
  input wire logic irq_o
);
  logic [7:0] m;
  logic [7:0] o;
  logic [1:0] quiet;
  logic wr, q, en, ms;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign q = quiet == 2'h3;
  assign en = q & m[6];
  assign ms = m[4];
  // pins lag writes; checks wait for a quiet bus
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m <= 8'h00;
      o <= 8'h00;
      quiet <= 2'h0;
    end else begin
      if (wr && wb_adr_i == scc_pkg::ADR_CTRL_MAIN) m <= wb_dat_i[7:0];
      if (wr && wb_adr_i == scc_pkg::ADR_CTRL_OPTIONS) o <= wb_dat_i[7:0];
      quiet <= wr ? 2'h0 : quiet + {1'b0, !q};
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_off; q && !m[6] |-> pin_spi_own_o == 4'h0; endproperty
  a_off: assert property (p_off) else $error("pins kept while off");
  property p_ss_gpio; en && ms && !o[4] |-> !pin_spi_own_o[3]; endproperty
  a_ss_gpio: assert property (p_ss_gpio) else $error("select pin not released");
  property p_ss_flt; en && ms && o[4] && !m[1] |-> pin_spi_own_o[3] && ss_pin_oe_n_o; endproperty
  a_ss_flt: assert property (p_ss_flt) else $error("select pin not fault input");
  property p_ss_auto; en && ms && o[4] && m[1] |-> pin_spi_own_o[3] && !ss_pin_oe_n_o; endproperty
  a_ss_auto: assert property (p_ss_auto) else $error("select pin not driven");
  property p_ss_slv; en && !ms |-> pin_spi_own_o[3] && ss_pin_oe_n_o; endproperty
  a_ss_slv: assert property (p_ss_slv) else $error("slave select not input");
  property p_sep_m; en && ms && !o[0] |-> !mosi_pin_oe_n_o && miso_pin_oe_n_o && pin_spi_own_o[2:0] == 3'h7; endproperty
  a_sep_m: assert property (p_sep_m) else $error("master data pins wrong");
  property p_sw_m; en && ms && o[0] |-> !pin_spi_own_o[2] && miso_pin_oe_n_o && mosi_pin_oe_n_o == !o[3]; endproperty
  a_sw_m: assert property (p_sw_m) else $error("single wire master pins wrong");
  property p_sw_s; en && !ms && o[0] |-> !pin_spi_own_o[1] && pin_spi_own_o[2] && mosi_pin_oe_n_o; endproperty
  a_sw_s: assert property (p_sw_s) else $error("single wire slave pins wrong");
  property p_opt_rd;
    wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && wb_adr_i == scc_pkg::ADR_CTRL_OPTIONS
      |-> (wb_dat_o[7:0] & 8'he4) == 8'h00;
  endproperty
  a_opt_rd: assert property (p_opt_rd) else $error("unused option bits read set");
  property p_irq_off; q && !m[7] && !m[5] |-> !irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enables clear");
  property p_irq_tx; q && !m[6] && m[5] |-> irq_o; endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("no tx irq while off");
  c_sw_m: cover property (en && ms && o[0]);
  c_fault: cover property (irq_o && m[7]);
  c_slave: cover property (en && !ms);
endmodule
bind scc_top scc_top_checker u_chk (.*);

// file: scc_top_tb.sv
// bench of the spi control block
`timescale 1ns/10ps
module scc_top_tb;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] d;
    logic [7:0] p;
  } scc_row_t;
  scc_row_t rows [4] = '{'{8'h52, 8'ha5, 8'h3c}, '{8'h5b, 8'h81, 8'h7e}, '{8'h57, 8'hc3, 8'h18}, '{8'h5e, 8'h0f, 8'hf0}};
  logic [15:0] pins [4] = '{16'h4001, 16'h5009, 16'h5001, 16'h5000};
  logic clk_sys_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wait_mode_i, irq_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, pin_spi_own_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_n_o;
  logic mosi_pin_i, mosi_pin_o, mosi_pin_oe_n_o, miso_pin_i, miso_pin_o, miso_pin_oe_n_o;
  logic ss_pin_i, ss_pin_o, ss_pin_oe_n_o, ss_drv, p_miso, p_clock_polarity, p_clock_phase, p_lsb;
  logic [7:0] p_tx, p_rx, r;
  int n_fail, comparisons, cycles;
  // pull-downs on clock and mosi, select follows ss_drv when released
  assign serial_clock_pin_i = serial_clock_pin_oe_n_o ? 1'b0 : serial_clock_pin_o;
  assign mosi_pin_i = mosi_pin_oe_n_o ? 1'b0 : mosi_pin_o;
  assign miso_pin_i = miso_pin_oe_n_o ? p_miso : miso_pin_o;
  assign ss_pin_i = ss_pin_oe_n_o ? ss_drv : ss_pin_o;
  scc_top dut (.*);
  scc_partner u_part (.sclk_i(serial_clock_pin_i), .ss_n_i(ss_pin_i), .mosi_i(mosi_pin_i), .miso_o(p_miso),
    .clock_polarity_i(p_clock_polarity), .clock_phase_i(p_clock_phase), .lsb_i(p_lsb), .tx_i(p_tx), .rx_o(p_rx));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // data writes need a status read first
  task automatic xfer(input logic [7:0] d);
    logic [7:0] q;
    bus(0, scc_pkg::ADR_STATUS, 8'h00, q);
    bus(1, scc_pkg::ADR_DATA, d, q);
    do bus(0, scc_pkg::ADR_STATUS, 8'h00, q); while (q[7] !== 1'b1);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wait_mode_i, p_clock_polarity, p_clock_phase, p_lsb} = 8'h00;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    ss_drv = 1'b1;
    p_tx = 8'h00;
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    bus(0, scc_pkg::ADR_CTRL_MAIN, 8'h00, r);
    chk(r, 8'h00);
    bus(0, scc_pkg::ADR_CTRL_OPTIONS, 8'h00, r);
    chk(r, 8'h00);
    bus(0, scc_pkg::ADR_STATUS, 8'h00, r);
    chk(r, 8'h20);
    chk({7'h0, irq_o}, 8'h00);
    bus(1, 5'h10, 8'hff, r);
    bus(0, 5'h10, 8'h00, r);
    chk(r, 8'h00);
    bus(1, scc_pkg::ADR_CTRL_OPTIONS, 8'hff, r);
    bus(0, scc_pkg::ADR_CTRL_OPTIONS, 8'h00, r);
    chk(r, 8'h1b);
    bus(1, scc_pkg::ADR_CTRL_OPTIONS, 8'h10, r);
    foreach (rows[i]) begin
      {p_clock_polarity, p_clock_phase, p_lsb} <= {rows[i].c1[3], rows[i].c1[2], rows[i].c1[0]};
      p_tx <= rows[i].p;
      bus(1, scc_pkg::ADR_CTRL_MAIN, rows[i].c1, r);
      xfer(rows[i].d);
      bus(0, scc_pkg::ADR_DATA, 8'h00, r);
      chk(r, rows[i].p);
      chk(p_rx, rows[i].d);
      chk({7'h0, serial_clock_pin_o}, {7'h0, rows[i].c1[3]});
    end
    foreach (pins[i]) begin
      bus(1, scc_pkg::ADR_CTRL_OPTIONS, pins[i][7:0], r);
      bus(1, scc_pkg::ADR_CTRL_MAIN, pins[i][15:8], r);
      repeat (8) @(posedge clk_sys_i);
    end
    bus(1, scc_pkg::ADR_CTRL_OPTIONS, 8'h10, r);
    bus(1, scc_pkg::ADR_CTRL_MAIN, 8'h52, r);
    {p_clock_polarity, p_clock_phase, p_lsb} <= 3'b000;
    xfer(8'h11);
    bus(1, scc_pkg::ADR_DATA, 8'h22, r);
    repeat (20) @(posedge clk_sys_i);
    bus(1, scc_pkg::ADR_CTRL_MAIN, 8'h20, r);
    bus(0, scc_pkg::ADR_STATUS, 8'h00, r);
    chk(r, 8'h20);
    chk({4'h0, pin_spi_own_o}, 8'h00);
    chk({7'h0, irq_o}, 8'h01);
    ss_drv <= 1'b0;
    bus(1, scc_pkg::ADR_CTRL_MAIN, 8'hd0, r);
    do bus(0, scc_pkg::ADR_STATUS, 8'h00, r); while (r[4] !== 1'b1);
    @(posedge clk_sys_i);
    chk({7'h0, irq_o}, 8'h01);
    end_sim();
  end
endmodule
